// ### lspc_apb_host.sv
// APB host model that drives the register bus of the load status block
`timescale 1ns/100ps
module lspc_apb_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; waits for pready, the bench watchdog cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    // Released data no longer shows the old word
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask : xfer
endmodule : lspc_apb_host

// ### lspc_load_if.sv
// Signals between the register side and the load measurement unit
`timescale 1ns/100ps
interface lspc_load_if;
  logic [9:0] cyc_result;
  logic [9:0] pwm_result;
  logic [9:0] ontime_a;
  logic [9:0] lower_lim;
  logic [9:0] upper_lim;
  logic pwm_mode;
  logic standstill;
  logic [9:0] result;
  logic stall;
  logic below_min;
  logic above_max;

  modport meas (
    input cyc_result, pwm_result, ontime_a, lower_lim, upper_lim, pwm_mode, standstill,
    output result, stall, below_min, above_max
  );
  modport ctrl (
    output cyc_result, pwm_result, ontime_a, lower_lim, upper_lim, pwm_mode, standstill,
    input result, stall, below_min, above_max
  );
endinterface : lspc_load_if

// ### lspc_load_meas.sv
// Load result selection, stall detection and limit compare
`timescale 1ns/100ps
module lspc_load_meas (
  input wire logic clk,
  input wire logic nrst,
  lspc_load_if.meas lif
);

  logic [9:0] result_reg;
  logic [9:0] result_next;
  logic stall_reg;
  logic stall_next;
  logic below_reg;
  logic below_next;
  logic above_reg;
  logic above_next;
  logic meas_ok;
  // Low until one edge after reset, so checks skip the release edge
  logic meas_live_reg;

  // A real load figure exists unless the cycle chopper is at standstill
  assign meas_ok = lif.pwm_mode || !lif.standstill;

  // Select the method matching the active chopper, then compare
  always_comb
  begin
    if (lif.pwm_mode)
      result_next = lif.pwm_result; // R03
    else if (lif.standstill)
      result_next = lif.ontime_a; // R07
    else
      result_next = lif.cyc_result; // R04
    // On-time is not a load figure, so it never flags a stall
    stall_next = meas_ok && (result_next == 10'h000); // R05
    // Current adaption compare is meaningless in voltage-PWM mode
    below_next = !lif.pwm_mode && !lif.standstill && (result_next < lif.lower_lim); // R06
    above_next = !lif.pwm_mode && !lif.standstill && (result_next >= lif.upper_lim); // R06
  end

  // State registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      result_reg <= 10'h000;
      stall_reg <= 1'b0;
      below_reg <= 1'b0;
      above_reg <= 1'b0;
      meas_live_reg <= 1'b0;
    end
    else
    begin
      result_reg <= result_next;
      stall_reg <= stall_next;
      below_reg <= below_next;
      above_reg <= above_next;
      meas_live_reg <= 1'b1;
    end
  end

  assign lif.result = result_reg;
  assign lif.stall = stall_reg;
  assign lif.below_min = below_reg;
  assign lif.above_max = above_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_result_pwm: assert property (meas_live_reg && lif.pwm_mode
      |=> lif.result == $past(lif.pwm_result)) // R03
    else $error("load result not from voltage-PWM measurement");
  chk_result_cycle: assert property (meas_live_reg && !lif.pwm_mode && !lif.standstill
      |=> lif.result == $past(lif.cyc_result)) // R04
    else $error("load result not from cycle measurement");
  chk_stall_zero: assert property (meas_live_reg && $past(meas_ok)
      && lif.result == 10'h000 |-> lif.stall) // R05
    else $error("zero load result without stall");
  chk_stall_only_zero: assert property (lif.stall |-> lif.result == 10'h000) // R05
    else $error("stall with nonzero load result");
  chk_limits_pwm_off: assert property (meas_live_reg && $past(lif.pwm_mode)
      |-> !lif.below_min && !lif.above_max) // R06
    else $error("limit compare active in voltage-PWM mode");
  chk_ontime_standstill: assert property (meas_live_reg && lif.standstill && !lif.pwm_mode
      |=> lif.result == $past(lif.ontime_a) && !lif.stall) // R07
    else $error("standstill result is not coil A on-time");

endmodule : lspc_load_meas

// ### lspc_pkg.sv
// Types shared by the load status block
package lspc_pkg;

  // Standstill option codes in ascending order 00..11
  typedef enum logic [1:0] {
    LSPC_HOLD_NORMAL,
    LSPC_HOLD_ZERO_HOLD_STANDSTILL_OPTION,
    LSPC_HOLD_SHORT_LS,
    LSPC_HOLD_SHORT_HS
  } lspc_hold_mode_t;

  // Voltage-PWM configuration layout, msb first
  typedef struct packed {
    logic [3:0] switchback_amplitude_cap;
    logic [3:0] regulation_gradient;
    logic standstill_regulation_off;
    logic slow_decay_current_measure_en;
    lspc_hold_mode_t zero_hold_standstill_option;
    logic auto_gradient_en;
    logic auto_scale_en;
    logic [1:0] chopper_frequency_select;
    logic [7:0] velocity_amplitude_gradient;
    logic [7:0] amplitude_offset;
  } lspc_pwm_conf_t;

endpackage : lspc_pkg

// ### lspc_regs.svh
// Register offsets, field positions and reset values of the load status block
`ifndef LSPC_REGS_SVH
`define LSPC_REGS_SVH

// Byte offsets on the register bus
`define LSPC_OFS_STATUS 8'h6C
`define LSPC_OFS_PWM_CONF 8'h70
`define LSPC_OFS_CTRL 8'h74
`define LSPC_OFS_LIMITS 8'h78
`define LSPC_OFS_IRQ_STAT 8'h7C
`define LSPC_OFS_IRQ_MASK 8'h80

// Status word field positions
`define LSPC_STAT_SUPPLY_SHORT_A_BIT 12
`define LSPC_STAT_STALL_BIT 24
`define LSPC_STAT_RESULT_MSB 9

// Control word: off-time setting in bits 3:0
`define LSPC_CTRL_OFF_TIME_MSB 3
`define LSPC_CTRL_RESET 32'h00000003

// Limits word: lower limit 9:0, upper limit 25:16
`define LSPC_LIM_LOWER_LSB 0
`define LSPC_LIM_UPPER_LSB 16
`define LSPC_LIMITS_RESET 32'h01000040
`define LSPC_LIMITS_MASK 32'h03FF03FF

// Voltage-PWM configuration reset value, all fields together
`define LSPC_PWM_CONF_RESET 32'hC40C001D

// Interrupt bits
`define LSPC_IRQ_SHORT_BIT 0
`define LSPC_IRQ_STALL_BIT 1
`define LSPC_IRQ_MASK_RESET 2'h0

`endif

// ### lspc_top.sv
// APB register bank: supply short flag, load status and voltage-PWM config
`timescale 1ns/100ps
`include "lspc_regs.svh"

// Notes on behaviour
// R01: Phase A supply short sets status bit 12 and turns the bridge off.
// R02: Short flag holds until off-time is zero or enable pin deasserted.
// R03: Status bits 9:0 carry the load result of the active chopper method.
// R04: Higher result means lower load; zero is highest load in cycle mode.
// R05: A zero load result raises the stall indication.
// R06: Result compared with upper and lower limits, not in voltage-PWM mode; code also skips the compare at standstill in cycle mode.
// R07: At standstill in cycle mode the result shows coil A on-time.
// R08: Voltage-PWM config is read/write, resets per field, reads back writes.
// R09: Config bits 31:28 cap amplitude bits 7:4 on switch back to PWM mode.
// R10: With zero hold current, option picks normal, zero_hold_standstill_option, LS short, HS short.
module lspc_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUPPLY_SHORT_A_DET,
  input wire logic ACTIVE_LOW_DRIVER_ENABLE_PIN_N,
  input wire logic [9:0] LOAD_CYCLE_RESULT,
  input wire logic [9:0] LOAD_PWM_RESULT,
  input wire logic PWM_MODE_ACTIVE,
  input wire logic MOTOR_STANDSTILL,
  input wire logic [9:0] COIL_A_ON_TIME,
  input wire logic HOLD_CURRENT_ZERO,
  input wire logic [7:0] AUTO_AMPLITUDE,
  input wire logic SWITCHBACK_TO_PWM,
  output logic BRIDGE_ENABLE,
  output logic STALL,
  output logic LOAD_BELOW_MIN,
  output logic LOAD_ABOVE_MAX,
  output logic [31:0] PWM_CONFIG,
  output logic [7:0] AMPLITUDE_CAPPED,
  output logic HOLD_ZERO_HOLD_STANDSTILL_OPTION,
  output logic HOLD_SHORT_LS,
  output logic HOLD_SHORT_HS,
  output logic IRQ
);

  // Address match, used by read mux and write strobes
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  lspc_load_if lif ();

  // Bus slave state
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] read_mux;

  // Register contents
  lspc_pkg::lspc_pwm_conf_t pwm_conf_reg;
  lspc_pkg::lspc_pwm_conf_t pwm_conf_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] limits_reg;
  logic [31:0] limits_next;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic irq_reg;
  logic irq_next;

  // Protection state
  logic short_meta_reg;
  logic short_sync_reg;
  logic drv_en_n_meta_reg;
  logic drv_en_n_sync_reg;
  logic short_flag_reg;
  logic short_flag_next;
  logic bridge_reg;
  logic bridge_next;
  logic driver_off;
  logic stall_prev_reg;

  // Derived outputs
  logic [7:0] amp_reg;
  logic [7:0] amp_next;
  logic [2:0] hold_reg;
  logic [2:0] hold_next;

  // Decode of the current APB phase
  assign access = PSEL && PENABLE;
  assign done = access && pready_reg;
  assign wr = done && PWRITE;
  assign rd = done && !PWRITE;
  assign mapped = reg_hit(PADDR, `LSPC_OFS_STATUS) || reg_hit(PADDR, `LSPC_OFS_PWM_CONF)
    || reg_hit(PADDR, `LSPC_OFS_CTRL) || reg_hit(PADDR, `LSPC_OFS_LIMITS)
    || reg_hit(PADDR, `LSPC_OFS_IRQ_STAT) || reg_hit(PADDR, `LSPC_OFS_IRQ_MASK);

  // Read data selection; unmapped reads return zero
  always_comb
  begin
    read_mux = 32'h00000000;
    if (reg_hit(PADDR, `LSPC_OFS_STATUS))
    begin
      read_mux[`LSPC_STAT_RESULT_MSB:0] = lif.result; // R03
      read_mux[`LSPC_STAT_SUPPLY_SHORT_A_BIT] = short_flag_reg; // R01
      read_mux[`LSPC_STAT_STALL_BIT] = lif.stall;
    end
    else if (reg_hit(PADDR, `LSPC_OFS_PWM_CONF))
      read_mux = pwm_conf_reg; // R08
    else if (reg_hit(PADDR, `LSPC_OFS_CTRL))
      read_mux = ctrl_reg;
    else if (reg_hit(PADDR, `LSPC_OFS_LIMITS))
      read_mux = limits_reg;
    else if (reg_hit(PADDR, `LSPC_OFS_IRQ_STAT))
      read_mux[1:0] = irq_stat_reg;
    else if (reg_hit(PADDR, `LSPC_OFS_IRQ_MASK))
      read_mux[1:0] = irq_mask_reg;
  end

  // One wait state so read data comes straight from a flip-flop
  always_comb
  begin
    pready_next = access && !pready_reg;
    pslverr_next = access && !pready_reg && !mapped;
    prdata_next = (access && !pready_reg) ? read_mux : prdata_reg;
  end

  // Bus slave registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Software writes; status register is read-only and ignores writes
  always_comb
  begin
    pwm_conf_next = pwm_conf_reg;
    ctrl_next = ctrl_reg;
    limits_next = limits_reg;
    irq_mask_next = irq_mask_reg;
    if (wr && reg_hit(PADDR, `LSPC_OFS_PWM_CONF))
      pwm_conf_next = PWDATA; // R08
    if (wr && reg_hit(PADDR, `LSPC_OFS_CTRL))
      ctrl_next = {28'h0000000, PWDATA[`LSPC_CTRL_OFF_TIME_MSB:0]};
    if (wr && reg_hit(PADDR, `LSPC_OFS_LIMITS))
      limits_next = PWDATA & `LSPC_LIMITS_MASK;
    if (wr && reg_hit(PADDR, `LSPC_OFS_IRQ_MASK))
      irq_mask_next = PWDATA[1:0];
  end

  // Configuration registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pwm_conf_reg <= `LSPC_PWM_CONF_RESET; // R08
      ctrl_reg <= `LSPC_CTRL_RESET;
      limits_reg <= `LSPC_LIMITS_RESET;
      irq_mask_reg <= `LSPC_IRQ_MASK_RESET;
    end
    else
    begin
      pwm_conf_reg <= pwm_conf_next;
      ctrl_reg <= ctrl_next;
      limits_reg <= limits_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      short_meta_reg <= 1'b0;
      short_sync_reg <= 1'b0;
      drv_en_n_meta_reg <= 1'b1;
      drv_en_n_sync_reg <= 1'b1;
    end
    else
    begin
      short_meta_reg <= SUPPLY_SHORT_A_DET;
      short_sync_reg <= short_meta_reg;
      drv_en_n_meta_reg <= ACTIVE_LOW_DRIVER_ENABLE_PIN_N;
      drv_en_n_sync_reg <= drv_en_n_meta_reg;
    end
  end

  // Driver counts as disabled by zero off-time or the enable pin
  assign driver_off = (ctrl_reg[`LSPC_CTRL_OFF_TIME_MSB:0] == 4'h0) || drv_en_n_sync_reg; // R02

  // Short latches; a new detection wins over the disable clear
  always_comb
  begin
    short_flag_next = short_sync_reg || (short_flag_reg && !driver_off); // R01 R02
    bridge_next = !short_flag_next && !driver_off; // R01
  end

  // Interrupt status: set wins over read clear
  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (rd && reg_hit(PADDR, `LSPC_OFS_IRQ_STAT))
      irq_stat_next = 2'h0;
    if (short_sync_reg && !short_flag_reg)
      irq_stat_next[`LSPC_IRQ_SHORT_BIT] = 1'b1;
    if (lif.stall && !stall_prev_reg)
      irq_stat_next[`LSPC_IRQ_STALL_BIT] = 1'b1;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // Protection and interrupt registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      short_flag_reg <= 1'b0;
      bridge_reg <= 1'b0;
      stall_prev_reg <= 1'b0;
      irq_stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      short_flag_reg <= short_flag_next;
      bridge_reg <= bridge_next;
      stall_prev_reg <= lif.stall;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
    end
  end

  // Amplitude cap on switch back; low nibble passes through
  always_comb
  begin
    amp_next = AUTO_AMPLITUDE;
    if (SWITCHBACK_TO_PWM && (AUTO_AMPLITUDE[7:4] > pwm_conf_reg.switchback_amplitude_cap))
      amp_next = {pwm_conf_reg.switchback_amplitude_cap, AUTO_AMPLITUDE[3:0]}; // R09
  end

  // Standstill option decode, only when hold current is zero
  always_comb
  begin
    hold_next = 3'h0;
    if (HOLD_CURRENT_ZERO)
    begin
      case (pwm_conf_reg.zero_hold_standstill_option) // R10
        lspc_pkg::LSPC_HOLD_NORMAL: hold_next = 3'h0;
        lspc_pkg::LSPC_HOLD_ZERO_HOLD_STANDSTILL_OPTION: hold_next = 3'h1;
        lspc_pkg::LSPC_HOLD_SHORT_LS: hold_next = 3'h2;
        lspc_pkg::LSPC_HOLD_SHORT_HS: hold_next = 3'h4;
        default: hold_next = 3'h0;
      endcase
    end
  end

  // Drive output registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      amp_reg <= 8'h00;
      hold_reg <= 3'h0;
    end
    else
    begin
      amp_reg <= amp_next;
      hold_reg <= hold_next;
    end
  end

  // Load measurement inputs come from the same clock domain
  assign lif.cyc_result = LOAD_CYCLE_RESULT;
  assign lif.pwm_result = LOAD_PWM_RESULT;
  assign lif.ontime_a = COIL_A_ON_TIME;
  assign lif.pwm_mode = PWM_MODE_ACTIVE;
  assign lif.standstill = MOTOR_STANDSTILL;
  assign lif.lower_lim = limits_reg[`LSPC_LIM_LOWER_LSB +: 10];
  assign lif.upper_lim = limits_reg[`LSPC_LIM_UPPER_LSB +: 10];

  lspc_load_meas u_meas (
    .clk(CLK),
    .nrst(NRST),
    .lif(lif)
  );

  // Output ports
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign BRIDGE_ENABLE = bridge_reg;
  assign STALL = lif.stall;
  assign LOAD_BELOW_MIN = lif.below_min;
  assign LOAD_ABOVE_MAX = lif.above_max;
  assign PWM_CONFIG = pwm_conf_reg;
  assign AMPLITUDE_CAPPED = amp_reg;
  assign HOLD_ZERO_HOLD_STANDSTILL_OPTION = hold_reg[0];
  assign HOLD_SHORT_LS = hold_reg[1];
  assign HOLD_SHORT_HS = hold_reg[2];
  assign IRQ = irq_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  chk_short_sets_flag: assert property (short_sync_reg
      |=> short_flag_reg && !BRIDGE_ENABLE) // R01
    else $error("supply short did not latch flag or stop bridge");
  chk_flag_holds: assert property (short_flag_reg && !driver_off |=> short_flag_reg) // R02
    else $error("supply short flag dropped while driver enabled");
  chk_flag_clears: assert property (driver_off && !short_sync_reg |=> !short_flag_reg) // R02
    else $error("supply short flag kept after driver disable");
  chk_pwm_conf_write: assert property (wr && reg_hit(PADDR, `LSPC_OFS_PWM_CONF)
      |=> PWM_CONFIG == $past(PWDATA) ##1 PWM_CONFIG == $past(PWDATA, 2)
      || $past(wr)) // R08
    else $error("voltage-PWM config does not hold written value");
  chk_cap_switchback: assert property (SWITCHBACK_TO_PWM
      |=> AMPLITUDE_CAPPED[7:4] <= $past(pwm_conf_reg.switchback_amplitude_cap)) // R09
    else $error("amplitude above cap after switch back");
  chk_hold_ls_short: assert property (HOLD_CURRENT_ZERO
      && pwm_conf_reg.zero_hold_standstill_option == lspc_pkg::LSPC_HOLD_SHORT_LS
      |=> HOLD_SHORT_LS && !HOLD_ZERO_HOLD_STANDSTILL_OPTION && !HOLD_SHORT_HS) // R10
    else $error("low-side short option not applied");
  chk_hold_none: assert property (!HOLD_CURRENT_ZERO
      |=> !HOLD_SHORT_LS && !HOLD_ZERO_HOLD_STANDSTILL_OPTION && !HOLD_SHORT_HS) // R10
    else $error("standstill option active with hold current");
  chk_apb_wait: assert property (access && !pready_reg |=> PREADY ##1 !PREADY)
    else $error("bus answer not one wait state");

endmodule : lspc_top

// ### testbench.sv
// Self-checking bench for the load status and voltage-PWM config block
`timescale 1ns/100ps
`include "lspc_regs.svh"
module testbench;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, det, pin_n, pm, st, hz, sb;
  logic [7:0] paddr, amp;
  logic [31:0] pwdata, prdata, rd, w;
  logic [9:0] cr, pr, ot, r;
  logic er, bridge, stall, below, above, fw, sls, shs, irq;
  logic [31:0] cfg;
  logic [7:0] capd;
  int n_mismatch, check_count, seed, i;

  lspc_top u_lspc_top (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SUPPLY_SHORT_A_DET(det), .ACTIVE_LOW_DRIVER_ENABLE_PIN_N(pin_n),
    .LOAD_CYCLE_RESULT(cr), .LOAD_PWM_RESULT(pr), .PWM_MODE_ACTIVE(pm),
    .MOTOR_STANDSTILL(st), .COIL_A_ON_TIME(ot), .HOLD_CURRENT_ZERO(hz),
    .AUTO_AMPLITUDE(amp), .SWITCHBACK_TO_PWM(sb), .BRIDGE_ENABLE(bridge), .STALL(stall),
    .LOAD_BELOW_MIN(below), .LOAD_ABOVE_MAX(above), .PWM_CONFIG(cfg),
    .AMPLITUDE_CAPPED(capd), .HOLD_ZERO_HOLD_STANDSTILL_OPTION(fw), .HOLD_SHORT_LS(sls),
    .HOLD_SHORT_HS(shs), .IRQ(irq));

  lspc_apb_host u_lspc_apb_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Expected amplitude after the switch-back cap
  function automatic logic [7:0] exp_cap(logic [7:0] a, logic [3:0] c);
    return (a[7:4] > c) ? {c, a[3:0]} : a;
  endfunction : exp_cap

  // Expected {hs, ls, zero_hold_standstill_option} for a standstill code
  function automatic logic [2:0] exp_hold(logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : (3'h1 << (c - 2'h1));
  endfunction : exp_hold

  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_lspc_apb_host.xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    u_lspc_apb_host.xfer(1'b0, a, 32'h00000000, rd, er);
  endtask : rdr

  // Let n edges pass, then look once their updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic summarize;
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog, far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    seed = 57572;
    {nrst, det, pin_n, pm, st, hz, sb} = 7'h00;
    {cr, pr, ot, amp} = {10'h155, 10'h0AA, 10'h033, 8'h00};
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Reset contents, then unmapped place
    rdr(`LSPC_OFS_PWM_CONF);
    chk_w("pwm_conf_reset", `LSPC_PWM_CONF_RESET, rd);
    rdr(`LSPC_OFS_LIMITS);
    chk_w("limits_reset", `LSPC_LIMITS_RESET, rd);
    rdr(8'h00);
    chk_b("unmapped_err", 1'b1, er);
    chk_w("unmapped_data", 32'h00000000, rd);
    chk_b("bridge_on", 1'b1, bridge);
    // Supply short: latches, holds, then cleared by off-time zero
    wr(`LSPC_OFS_IRQ_MASK, 32'h00000001);
    @(posedge clk);
    det <= 1'b1;
    settle(4);
    chk_b("bridge_off", 1'b0, bridge);
    chk_b("irq_short", 1'b1, irq);
    @(posedge clk);
    det <= 1'b0;
    rdr(`LSPC_OFS_STATUS);
    chk_b("short_flag", 1'b1, rd[12]);
    rdr(`LSPC_OFS_IRQ_STAT);
    chk_b("irq_stat", 1'b1, rd[0]);
    rdr(`LSPC_OFS_STATUS);
    chk_b("short_held", 1'b1, rd[12]);
    settle(2);
    chk_b("irq_cleared", 1'b0, irq);
    wr(`LSPC_OFS_CTRL, 32'h00000000);
    rdr(`LSPC_OFS_STATUS);
    chk_b("short_clear", 1'b0, rd[12]);
    wr(`LSPC_OFS_CTRL, `LSPC_CTRL_RESET);
    // Second short, this time cleared through the enable pin
    @(posedge clk);
    det <= 1'b1;
    settle(4);
    @(posedge clk);
    det <= 1'b0;
    pin_n <= 1'b1;
    settle(4);
    rdr(`LSPC_OFS_STATUS);
    chk_b("short_pin_clear", 1'b0, rd[12]);
    chk_b("bridge_pin_off", 1'b0, bridge);
    @(posedge clk);
    pin_n <= 1'b0;
    settle(4);
    chk_b("bridge_back", 1'b1, bridge);
    // Load result selection, stall and limits; first three are corners
    for (i = 0; i < 24; i++)
    begin
      @(posedge clk);
      pm <= (i < 3) ? 1'b0 : 1'($random(seed));
      st <= (i < 2) ? 1'b0 : ((i == 2) ? 1'b1 : 1'($random(seed)));
      cr <= (i < 2) ? 10'h000 : 10'($random(seed));
      pr <= 10'($random(seed));
      ot <= (i == 2) ? 10'h000 : 10'($random(seed));
      settle(2);
      r = pm ? pr : (st ? ot : cr);
      chk_b("stall", (pm || !st) && r == 10'h000, stall);
      chk_b("below", !pm && !st && r < 10'h040, below);
      chk_b("above", !pm && !st && r >= 10'h100, above);
      rdr(`LSPC_OFS_STATUS);
      chk_w("result", {22'h000000, r}, {22'h000000, rd[9:0]});
      chk_b("stall_bit", (pm || !st) && r == 10'h000, rd[24]);
    end
    // Config read-back, switch-back cap and standstill codes
    for (i = 0; i < 8; i++)
    begin
      w = $random(seed);
      w[21:20] = 2'(i);
      wr(`LSPC_OFS_PWM_CONF, w);
      rdr(`LSPC_OFS_PWM_CONF);
      chk_w("pwm_conf", w, rd);
      chk_w("pwm_config_port", w, cfg);
      @(posedge clk);
      amp <= (i == 0) ? 8'hFF : 8'($random(seed));
      // Odd passes leave the cap off, pass five has hold current
      sb <= (i % 2 == 0);
      hz <= (i != 5);
      settle(3);
      chk_w("amp_capped", {24'h000000, sb ? exp_cap(amp, w[31:28]) : amp},
        {24'h000000, capd});
      chk_w("hold", {29'h0, hz ? exp_hold(w[21:20]) : 3'h0},
        {29'h0, shs, sls, fw});
    end
    summarize();
  end
endmodule : testbench
